// [design/cpu_regs_params.svh]
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

// Address space
`define ADDR_WIDTH        16
`define DIRECT_PAGE_HI    8'h00

// Reset values
`define PAIR_HI_RESET     8'h00
`define STACK_PTR_RESET   16'h00ff
`define PROG_CNT_RESET    16'h0000
`define COND_CODE_RESET   8'h68

// Reset vector locations
`define VEC_HI_ADDR       16'hfffe
`define VEC_LO_ADDR       16'hffff

// Condition code fields
`define COND_FIXED_MASK   8'h60
`define COND_IMASK_BIT    3

// Stack details
`define STACK_LOW_VALUE   8'hff
`define CALL_PUSH_LAST    3'd1
`define IRQ_PUSH_LAST     3'd4

`endif

// [design/cpu_regs_pkg.sv]
package cpu_regs_pkg;

   typedef enum logic [4:0] {
      OP_NONE,
      OP_FETCH,
      OP_JUMP,
      OP_BRANCH,
      OP_CALL,
      OP_IRQ,
      OP_WR_RESULT,
      OP_WR_PAIR_LO,
      OP_WR_PAIR_HI,
      OP_WR_PAIR,
      OP_WR_STACK_PTR,
      OP_WR_COND,
      OP_ADD_TO_STACK_PTR,
      OP_STACK_LOW_RELOAD,
      OP_PUSH,
      OP_PULL,
      OP_PAIR_INC
   } reg_op_e;

   typedef enum logic [2:0] {
      AM_DIRECT,
      AM_EXTENDED,
      AM_IDX,
      AM_IDX_OFF8,
      AM_IDX_OFF16,
      AM_STK_OFF8,
      AM_STK_OFF16,
      AM_RELATIVE
   } addr_mode_e;

   // Sign extension of an 8-bit two's-complement value
   function automatic logic [15:0] sext8(input logic [7:0] v);
      return {{8{v[7]}}, v};
   endfunction

endpackage

// [design/ea_calc.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"

module ea_calc
   import cpu_regs_pkg::*;
(
   input  wire addr_mode_e  mode_in,
   input  wire logic [15:0] pair_in,
   input  wire logic [15:0] stack_ptr_in,
   input  wire logic [15:0] prog_cnt_in,
   input  wire logic [15:0] operand_in,
   output logic      [15:0] ea_out
);

   always_comb
   begin
      unique case (mode_in)
         AM_DIRECT:    ea_out = {`DIRECT_PAGE_HI, operand_in[7:0]};
         AM_EXTENDED:  ea_out = operand_in;
         AM_IDX:       ea_out = pair_in;
         AM_IDX_OFF8:  ea_out = pair_in + {8'h00, operand_in[7:0]};
         AM_IDX_OFF16: ea_out = pair_in + operand_in;
         AM_STK_OFF8:  ea_out = stack_ptr_in + {8'h00, operand_in[7:0]};
         AM_STK_OFF16: ea_out = stack_ptr_in + operand_in;
         AM_RELATIVE:  ea_out = prog_cnt_in + sext8(operand_in[7:0]);
      endcase
   end

endmodule
`default_nettype wire

// [design/cpu_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"

// Overview of operation
// - The result register has no reset and keeps its value across reset.
// - The upper byte of the pointer pair is forced to zero during reset.
// - The lower byte of the pointer pair has no reset.
// - The stack pointer is loaded with 0x00ff at reset.
// - Add-to-stack-pointer adds a sign-extended byte to all 16 bits.
// - Stack-low-reload changes only the low byte of the stack pointer.
// - After reset the program counter is read from 0xfffe and 0xffff.
// - Each fetch advances the program counter unless flow changes.
// - Bits 6 and 5 of the condition code register always read as one.
// - Indexed addresses use the full 16-bit pointer pair.
// - Direct addresses reach only 0x0000 through 0x00ff.
// - Branch targets add a signed byte offset to the program counter.
// - The stack pointer always addresses the next free stack byte.
// - Interrupts push return address and registers; calls push address.
// - All memory lives in one 16-bit, 64 Kbyte address space.
// - Core registers are never decoded at any memory address.
module cpu_regs
   import cpu_regs_pkg::*;
#(
   parameter int ADDR_W = `ADDR_WIDTH
)
(
   input  wire logic        core_clk_in,
   input  wire logic        resetn_in,
   input  wire reg_op_e     op_in,
   input  wire logic [15:0] op_data_in,
   input  wire addr_mode_e  ea_mode_in,
   input  wire logic [7:0]  mem_rdata_in,
   output logic             busy_out,
   output logic [15:0]      mem_addr_out,
   output logic             mem_rd_out,
   output logic             mem_wr_out,
   output logic [7:0]       mem_wdata_out,
   output logic [15:0]      ea_out,
   output logic [7:0]       result_register_out,
   output logic [15:0]      pointer_pair_out,
   output logic [15:0]      stack_pointer_out,
   output logic [15:0]      program_counter_out,
   output logic [7:0]       condition_code_register_out
);

   typedef enum logic [2:0] {
      ST_VEC_HI,
      ST_VEC_LO,
      ST_CAP_HI,
      ST_CAP_LO,
      ST_RUN,
      ST_STACK
   } seq_state_e;

   generate
      if (ADDR_W != 16)
      begin : g_bad_width
         $error("cpu_regs supports only a 16-bit address space");
      end
   endgenerate

   seq_state_e  state;
   logic [7:0]  result_register;
   logic [7:0]  pair_hi;
   logic [7:0]  pair_lo;
   logic [15:0] stack_pointer;
   logic [15:0] program_counter;
   logic [7:0]  condition_code_register;
   logic [2:0]  stack_idx;
   logic [2:0]  stack_last;
   logic [15:0] stack_target;
   logic        stack_is_irq;
   logic [15:0] next_ea;
   logic [15:0] pair_inc;
   logic [15:0] stack_up;
   logic        run;
   logic        stack_done;

   function automatic logic [7:0] push_byte(input logic [2:0] idx);
      unique case (idx)
         3'd0:    return program_counter[7:0];
         3'd1:    return program_counter[15:8];
         3'd2:    return pair_lo;
         3'd3:    return result_register;
         default: return condition_code_register;
      endcase
   endfunction

   assign run        = (state == ST_RUN);
   assign stack_done = (state == ST_STACK) && (stack_idx == stack_last);
   assign pair_inc   = {pair_hi, pair_lo} + 16'h0001;
   assign stack_up   = stack_pointer + 16'h0001;
   assign busy_out   = !run;

   // Registers exposed only as ports, never decoded at a memory address
   assign result_register_out         = result_register;
   assign pointer_pair_out            = {pair_hi, pair_lo};
   assign stack_pointer_out           = stack_pointer;
   assign program_counter_out         = program_counter;
   assign condition_code_register_out = condition_code_register;

   ea_calc u_ea_calc
   (
      .mode_in      (ea_mode_in),
      .pair_in      ({pair_hi, pair_lo}),
      .stack_ptr_in (stack_pointer),
      .prog_cnt_in  (program_counter),
      .operand_in   (op_data_in),
      .ea_out       (next_ea)
   );

   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         ea_out <= 16'h0000;
      else
         ea_out <= next_ea;
   end

   // Sequencer
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         state <= ST_VEC_HI;
      else
      begin
         unique case (state)
            ST_VEC_HI: state <= ST_VEC_LO;
            ST_VEC_LO: state <= ST_CAP_HI;
            ST_CAP_HI: state <= ST_CAP_LO;
            ST_CAP_LO: state <= ST_RUN;
            ST_RUN:
            begin
               if (op_in == OP_CALL || op_in == OP_IRQ)
                  state <= ST_STACK;
            end
            ST_STACK:
            begin
               if (stack_done)
                  state <= ST_RUN;
            end
         endcase
      end
   end

   // Stack sequence bookkeeping
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         stack_idx    <= 3'd0;
         stack_last   <= 3'd0;
         stack_target <= 16'h0000;
         stack_is_irq <= 1'b0;
      end
      else if (run && (op_in == OP_CALL || op_in == OP_IRQ))
      begin
         stack_idx    <= 3'd0;
         stack_is_irq <= (op_in == OP_IRQ);
         stack_target <= op_data_in;
         stack_last   <= (op_in == OP_IRQ) ? `IRQ_PUSH_LAST
                                           : `CALL_PUSH_LAST;
      end
      else if (state == ST_STACK)
         stack_idx <= stack_idx + 3'd1;
   end

   // Memory strobes, one 16-bit space
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         mem_addr_out  <= 16'h0000;
         mem_rd_out    <= 1'b0;
         mem_wr_out    <= 1'b0;
         mem_wdata_out <= 8'h00;
      end
      else
      begin
         mem_rd_out <= 1'b0;
         mem_wr_out <= 1'b0;
         unique case (state)
            ST_VEC_HI:
            begin
               mem_addr_out <= `VEC_HI_ADDR;
               mem_rd_out   <= 1'b1;
            end
            ST_VEC_LO:
            begin
               mem_addr_out <= `VEC_LO_ADDR;
               mem_rd_out   <= 1'b1;
            end
            ST_STACK:
            begin
               mem_addr_out  <= stack_pointer;
               mem_wdata_out <= push_byte(stack_idx);
               mem_wr_out    <= 1'b1;
            end
            ST_RUN:
            begin
               if (op_in == OP_FETCH)
               begin
                  mem_addr_out <= program_counter;
                  mem_rd_out   <= 1'b1;
               end
               else if (op_in == OP_PUSH)
               begin
                  mem_addr_out  <= stack_pointer;
                  mem_wdata_out <= op_data_in[7:0];
                  mem_wr_out    <= 1'b1;
               end
               else if (op_in == OP_PULL)
               begin
                  mem_addr_out <= stack_up;
                  mem_rd_out   <= 1'b1;
               end
            end
            ST_CAP_HI, ST_CAP_LO: ;
         endcase
      end
   end

   // Result register, kept across reset
   always_ff @(posedge core_clk_in)
   begin
      if (run && op_in == OP_WR_RESULT)
         result_register <= op_data_in[7:0];
   end

   // Pointer pair low byte, kept across reset
   always_ff @(posedge core_clk_in)
   begin
      if (run && (op_in == OP_WR_PAIR_LO || op_in == OP_WR_PAIR))
         pair_lo <= op_data_in[7:0];
      else if (run && op_in == OP_PAIR_INC)
         pair_lo <= pair_inc[7:0];
   end

   // Pointer pair high byte
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         pair_hi <= `PAIR_HI_RESET;
      else if (run && op_in == OP_WR_PAIR_HI)
         pair_hi <= op_data_in[7:0];
      else if (run && op_in == OP_WR_PAIR)
         pair_hi <= op_data_in[15:8];
      else if (run && op_in == OP_PAIR_INC)
         pair_hi <= pair_inc[15:8];
   end

   // Stack pointer, always the next free byte
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         stack_pointer <= `STACK_PTR_RESET;
      else if (state == ST_STACK)
         stack_pointer <= stack_pointer - 16'h0001;
      else if (run)
      begin
         unique case (op_in)
            OP_WR_STACK_PTR:
               stack_pointer <= op_data_in;
            OP_ADD_TO_STACK_PTR:
               stack_pointer <= stack_pointer
                              + sext8(op_data_in[7:0]);
            OP_STACK_LOW_RELOAD:
               stack_pointer[7:0] <= `STACK_LOW_VALUE;
            OP_PUSH:
               stack_pointer <= stack_pointer - 16'h0001;
            OP_PULL:
               stack_pointer <= stack_up;
            default: ;
         endcase
      end
   end

   // Program counter
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         program_counter <= `PROG_CNT_RESET;
      else if (state == ST_CAP_HI)
         program_counter[15:8] <= mem_rdata_in;
      else if (state == ST_CAP_LO)
         program_counter[7:0] <= mem_rdata_in;
      else if (stack_done)
         program_counter <= stack_target;
      else if (run && op_in == OP_FETCH)
         program_counter <= program_counter + 16'h0001;
      else if (run && op_in == OP_JUMP)
         program_counter <= op_data_in;
      else if (run && op_in == OP_BRANCH)
         program_counter <= program_counter
                          + sext8(op_data_in[7:0]);
   end

   // Condition codes with fixed bits held high
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         condition_code_register <= `COND_CODE_RESET;
      else if (run && op_in == OP_WR_COND)
         condition_code_register <= op_data_in[7:0]
                                  | `COND_FIXED_MASK;
      else if (stack_done && stack_is_irq)
         condition_code_register[`COND_IMASK_BIT] <= 1'b1;
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);

   hi_reset_zero_a:
      assert property (state == ST_VEC_HI |-> pair_hi == 8'h00)
      else $error("pair high byte not zero after reset");

   stack_reset_a:
      assert property (state == ST_VEC_HI |-> stack_pointer == 16'h00ff)
      else $error("stack pointer not 0x00ff after reset");

   vector_load_a:
      assert property (state == ST_CAP_LO |=> program_counter
         == {$past(mem_rdata_in, 2), $past(mem_rdata_in)})
      else $error("program counter not loaded from reset vector");

   vector_addr_a:
      assert property (state == ST_VEC_HI |=> mem_rd_out
         && mem_addr_out == 16'hfffe ##1 mem_rd_out
         && mem_addr_out == 16'hffff)
      else $error("reset vector read order wrong");

   fetch_advance_a:
      assert property (run && op_in == OP_FETCH |=> mem_rd_out
         && mem_addr_out == $past(program_counter)
         && program_counter == $past(program_counter) + 16'h0001)
      else $error("fetch did not advance program counter");

   cond_fixed_a:
      assert property (condition_code_register[6:5] == 2'b11)
      else $error("fixed condition code bits not set");

   stack_add_a:
      assert property (run && op_in == OP_ADD_TO_STACK_PTR |=>
         stack_pointer == $past(stack_pointer)
         + sext8($past(op_data_in[7:0])))
      else $error("stack add not sign extended");

   low_reload_a:
      assert property (run && op_in == OP_STACK_LOW_RELOAD |=>
         stack_pointer == {$past(stack_pointer[15:8]), 8'hff})
      else $error("stack low reload touched high byte");

   branch_target_a:
      assert property (run && op_in == OP_BRANCH |=>
         program_counter == $past(program_counter)
         + sext8($past(op_data_in[7:0])))
      else $error("branch target wrong");

   push_order_a:
      assert property (run && op_in == OP_PUSH |=> mem_wr_out
         && mem_addr_out == $past(stack_pointer)
         && stack_pointer == $past(stack_pointer) - 16'h0001)
      else $error("push not write then decrement");

   pull_order_a:
      assert property (run && op_in == OP_PULL |=> mem_rd_out
         && mem_addr_out == $past(stack_pointer) + 16'h0001
         && stack_pointer == mem_addr_out)
      else $error("pull not increment then read");

   irq_push_a:
      assert property (run && op_in == OP_IRQ |=> ##1 mem_wr_out[*5])
      else $error("interrupt entry did not push five bytes");

   irq_vector_a:
      assert property (run && op_in == OP_IRQ |-> ##6
         program_counter == $past(op_data_in, 6)
         && condition_code_register[3])
      else $error("interrupt entry did not load target");

   index_full_a:
      assert property (ea_mode_in == AM_IDX |=> ea_out
         == $past({pair_hi, pair_lo}))
      else $error("indexed address not full pointer pair");

   direct_page_a:
      assert property (ea_mode_in == AM_DIRECT |=> ea_out[15:8] == 8'h00)
      else $error("direct address outside first page");

   cover_boot_c:   cover property (state == ST_CAP_LO ##1 run);
   cover_irq_c:    cover property (run && op_in == OP_IRQ ##6 run);
   cover_call_c:   cover property (run && op_in == OP_CALL);
   cover_back_c:   cover property (run && op_in == OP_BRANCH
                                   && op_data_in[7]);
   cover_pull_c:   cover property (run && op_in == OP_PUSH
                                   ##1 run && op_in == OP_PULL);

endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
   import cpu_regs_pkg::*;
;
   logic        core_clk_in;
   logic        resetn_in;
   reg_op_e     op_in;
   logic [15:0] op_data_in;
   addr_mode_e  ea_mode_in;
   logic [7:0]  mem_rdata_in;
   logic        busy_out;
   logic [15:0] mem_addr_out;
   logic        mem_rd_out;
   logic        mem_wr_out;
   logic [7:0]  mem_wdata_out;
   logic [15:0] ea_out;
   logic [7:0]  result_register_out;
   logic [15:0] pointer_pair_out;
   logic [15:0] stack_pointer_out;
   logic [15:0] program_counter_out;
   logic [7:0]  condition_code_register_out;
   logic [7:0]  mem [0:65535];
   int          err_count;
   int          comparisons;
   logic [15:0] exp_ea;

   cpu_regs u_dut (
      .core_clk_in                 (core_clk_in),
      .resetn_in                   (resetn_in),
      .op_in                       (op_in),
      .op_data_in                  (op_data_in),
      .ea_mode_in                  (ea_mode_in),
      .mem_rdata_in                (mem_rdata_in),
      .busy_out                    (busy_out),
      .mem_addr_out                (mem_addr_out),
      .mem_rd_out                  (mem_rd_out),
      .mem_wr_out                  (mem_wr_out),
      .mem_wdata_out               (mem_wdata_out),
      .ea_out                      (ea_out),
      .result_register_out         (result_register_out),
      .pointer_pair_out            (pointer_pair_out),
      .stack_pointer_out           (stack_pointer_out),
      .program_counter_out         (program_counter_out),
      .condition_code_register_out (condition_code_register_out)
   );

   always #4 core_clk_in = ~core_clk_in;

   // Memory: writes land, reads answer next cycle, idle data toggles
   always @(posedge core_clk_in)
   begin
      if (mem_wr_out === 1'b1)
         mem[mem_addr_out] <= mem_wdata_out;
      if (mem_rd_out === 1'b1)
         mem_rdata_in <= mem[mem_addr_out];
      else
         mem_rdata_in <= ~mem_rdata_in;
   end

   task automatic final_report();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wait_idle();
      int i;
      for (i = 0; i < 20; i++)
      begin
         @(posedge core_clk_in);
         #1;
         if (busy_out === 1'b0)
            return;
      end
      err_count++;
      $display("[FAIL] busy_out expected 0 seen %b", busy_out);
      final_report();
   endtask

   task automatic op(input reg_op_e o, input logic [15:0] d);
      @(posedge core_clk_in);
      op_in <= o;
      op_data_in <= d;
      @(posedge core_clk_in);
      op_in <= OP_NONE;
      #1;
   endtask

   task automatic do_reset();
      @(posedge core_clk_in);
      resetn_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1;
      chk("sp_in_reset", stack_pointer_out, 16'h00ff);
      @(posedge core_clk_in);
      resetn_in <= 1'b1;
      wait_idle();
      chk("pc_vector", program_counter_out, 16'h1234);
      chk("sp_reset", stack_pointer_out, 16'h00ff);
      chk("pair_hi", {8'h00, pointer_pair_out[15:8]}, 16'h0000);
      chk("cond_fix", {8'h00, condition_code_register_out & 8'h60},
          16'h0060);
   endtask

   initial
   begin
      core_clk_in = 1'b0;
      resetn_in = 1'b0;
      op_in = OP_NONE;
      op_data_in = 16'h0000;
      ea_mode_in = AM_DIRECT;
      mem_rdata_in = 8'h00;
      err_count = 0;
      comparisons = 0;
      mem[16'hfffe] = 8'h12;
      mem[16'hffff] = 8'h34;
      repeat (3) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      wait_idle();
      chk("pc_vector", program_counter_out, 16'h1234);
      chk("sp_reset", stack_pointer_out, 16'h00ff);
      chk("cond_reset", {8'h00, condition_code_register_out}, 16'h0068);
      // Values kept and forced across a second reset
      op(OP_WR_RESULT, 16'h005a);
      chk("no_rd", {15'h0, mem_rd_out}, 16'h0000);
      chk("no_wr", {15'h0, mem_wr_out}, 16'h0000);
      op(OP_WR_PAIR, 16'ha5c3);
      chk("pair_wr", pointer_pair_out, 16'ha5c3);
      do_reset();
      chk("result_kept", {8'h00, result_register_out}, 16'h005a);
      chk("pair_lo_kept", pointer_pair_out, 16'h00c3);
      // Fetch and change of flow
      op(OP_FETCH, 16'h0000);
      chk("fetch_rd", {15'h0, mem_rd_out}, 16'h0001);
      chk("fetch_addr", mem_addr_out, 16'h1234);
      chk("fetch_pc", program_counter_out, 16'h1235);
      op(OP_BRANCH, 16'h0080);
      chk("branch_back", program_counter_out, 16'h11b5);
      op(OP_BRANCH, 16'h007f);
      chk("branch_fwd", program_counter_out, 16'h1234);
      op(OP_JUMP, 16'h4000);
      chk("jump_pc", program_counter_out, 16'h4000);
      // Stack pointer adjustment
      op(OP_WR_STACK_PTR, 16'h0100);
      op(OP_ADD_TO_STACK_PTR, 16'h00fe);
      chk("ais_neg", stack_pointer_out, 16'h00fe);
      op(OP_ADD_TO_STACK_PTR, 16'h0005);
      chk("ais_pos", stack_pointer_out, 16'h0103);
      op(OP_WR_STACK_PTR, 16'h1234);
      op(OP_STACK_LOW_RELOAD, 16'h0000);
      chk("low_reload", stack_pointer_out, 16'h12ff);
      // Push then pull
      op(OP_WR_STACK_PTR, 16'h0200);
      op(OP_PUSH, 16'h0077);
      chk("push_wr", {15'h0, mem_wr_out}, 16'h0001);
      chk("push_addr", mem_addr_out, 16'h0200);
      chk("push_data", {8'h00, mem_wdata_out}, 16'h0077);
      chk("push_sp", stack_pointer_out, 16'h01ff);
      op(OP_PULL, 16'h0000);
      chk("pull_rd", {15'h0, mem_rd_out}, 16'h0001);
      chk("pull_addr", mem_addr_out, 16'h0200);
      chk("pull_sp", stack_pointer_out, 16'h0200);
      @(posedge core_clk_in);
      #1;
      chk("pull_data", {8'h00, mem_rdata_in}, 16'h0077);
      // Fixed condition bits
      op(OP_WR_COND, 16'h0000);
      chk("cond_zero", {8'h00, condition_code_register_out},
          16'h0060);
      op(OP_WR_COND, 16'h0001);
      chk("cond_one", {8'h00, condition_code_register_out},
          16'h0061);
      // Effective address for every mode
      op(OP_WR_PAIR, 16'h12f0);
      for (int m = 0; m < 8; m++)
      begin
         @(posedge core_clk_in);
         ea_mode_in <= addr_mode_e'(m);
         op_data_in <= 16'h0180;
         case (m)
            0: exp_ea = 16'h0080;
            1: exp_ea = 16'h0180;
            2: exp_ea = 16'h12f0;
            3: exp_ea = 16'h1370;
            4: exp_ea = 16'h1470;
            5: exp_ea = 16'h0280;
            6: exp_ea = 16'h0380;
            default: exp_ea = 16'h3f80;
         endcase
         @(posedge core_clk_in);
         #1;
         chk("ea_mode", ea_out, exp_ea);
      end
      // Interrupt entry then call
      op(OP_WR_STACK_PTR, 16'h0300);
      op(OP_IRQ, 16'h8000);
      chk("irq_busy", {15'h0, busy_out}, 16'h0001);
      wait_idle();
      @(posedge core_clk_in);
      #1;
      chk("irq_pcl", {8'h00, mem[16'h0300]}, 16'h0000);
      chk("irq_pch", {8'h00, mem[16'h02ff]}, 16'h0040);
      chk("irq_lo", {8'h00, mem[16'h02fe]}, 16'h00f0);
      chk("irq_res", {8'h00, mem[16'h02fd]}, 16'h005a);
      chk("irq_cond", {8'h00, mem[16'h02fc]}, 16'h0061);
      chk("irq_sp", stack_pointer_out, 16'h02fb);
      chk("irq_pc", program_counter_out, 16'h8000);
      chk("irq_mask", {8'h00, condition_code_register_out}, 16'h0069);
      op(OP_CALL, 16'h9000);
      wait_idle();
      @(posedge core_clk_in);
      #1;
      chk("call_pcl", {8'h00, mem[16'h02fb]}, 16'h0000);
      chk("call_pch", {8'h00, mem[16'h02fa]}, 16'h0080);
      chk("call_sp", stack_pointer_out, 16'h02f9);
      chk("call_pc", program_counter_out, 16'h9000);
      final_report();
   end
endmodule
`default_nettype wire
